/* File: atsc_top.sv */
// Task-file drive/head, status, alternate status and device control.
// Assumes the host port strobes are one-cycle pulses on CLK_I and that
// the core flags and the configuration copy field are on the same clock.
//
// Notes on behaviour
// - Drive bit clear selects card 0, set selects card 1.
// - In PC Card modes the copy field picks which card answers.
// - Block address joins sector, cylinder low/high and head nibble.
// - Status reads at 7, an identical copy reads at Eh.
// - Primary status read clears pending interrupt; the copy does not.
// - Busy set while device owns registers; host stays off them.
// - Ready is clear from power-up until commands can be taken.
// - Data request bit shows the device wants a data transfer.
// - Corrected error bit set on fixed error, reads continue.
// - Index bit always reads zero.
// - Error bit flags a failed previous command.
// - Device control is write-only at Eh, shared with status copy.
// - Control bit 2 set holds soft reset until written back to 0.
// - Soft reset leaves PC Card configuration untouched.
// - Control bit 1 low enables interrupts, high suppresses them.
// - That enable bit also drives the configuration Int bit.
// - The enable bit is zero after power-on and reset.
// - Control bits 3 and 0 ignored, bits 7..4 don't care.
`timescale 1ns/1ps
`default_nettype none
module atsc_top #(
    parameter int unsigned DRIVE_ID       = 0,
    parameter int unsigned RECOVER_CYCLES = atsc_pkg::RECOVER_CYCLES
) (
    input  wire logic        CLK_I,           // Block clock, 200 MHz.
    input  wire logic        RST_I,           // Hardware reset, high.
    input  wire logic [3:0]  REG_ADDR_I,      // Task-file offset.
    input  wire logic [7:0]  REG_WDATA_I,     // Write data.
    input  wire logic        REG_WR_I,        // Write strobe pulse.
    input  wire logic        REG_RD_I,        // Read strobe pulse.
    input  wire logic        PCCARD_MODE_I,   // Memory or I/O mode.
    input  wire logic [2:0]  COPY_FIELD_I,    // Socket/copy field.
    input  wire logic        CORE_BUSY_I,     // Core owns registers.
    input  wire logic        CORE_READY_I,    // Core accepts commands.
    input  wire logic        WRITE_FAULT_I,   // Write fault level.
    input  wire logic        SEEK_DONE_I,     // Seek complete level.
    input  wire logic        DATA_REQ_I,      // Data transfer wanted.
    input  wire logic        CORRECTED_ERROR_FLAG_EVENT_I,    // Corrected error pulse.
    input  wire logic        CMD_ERROR_I,     // Last command failed.
    input  wire logic        IRQ_EVENT_I,     // Interrupt cause pulse.
    input  wire logic [7:0]  SECTOR_NUM_I,    // Sector number byte.
    input  wire logic [7:0]  CYL_LOW_I,       // Cylinder low byte.
    input  wire logic [7:0]  CYL_HIGH_I,      // Cylinder high byte.
    output logic      [7:0]  REG_RDATA_O,     // Read data, next cycle.
    output logic             IRQ_O,           // Interrupt to host.
    output logic             CFG_INT_O,       // Config Int bit.
    output logic             SOFT_RESET_O,    // Soft reset to core.
    output logic             CARD_SEL_O,      // This card addressed.
    output logic      [27:0] LBA_O,           // Block address.
    output logic      [3:0]  HEAD_O,          // Head number.
    output logic             LBA_MODE_O       // Block addressing on.
);

    // Parameters the logic cannot serve are refused at elaboration.
    if (DRIVE_ID > 1) begin : g_bad_drive
        $error("DRIVE_ID must be 0 or 1");
    end
    if (RECOVER_CYCLES < 1 || RECOVER_CYCLES > 15) begin : g_bad_rec
        $error("RECOVER_CYCLES must be 1 to 15");
    end

    localparam logic [3:0] REC_LOAD = RECOVER_CYCLES[3:0];
    localparam logic       OWN_CARD = DRIVE_ID[0];

    // Strobe and offset match, shared by every register decode.
    function automatic logic hit(input logic       strobe,
                                 input logic [3:0] addr,
                                 input logic [3:0] ofs);
        hit = strobe & (addr == ofs);
    endfunction

    atsc_pkg::atsc_state_t st;
    atsc_pkg::atsc_state_t next_st;

    atsc_link_if lnk ();

    logic busy;
    logic rd_status;
    logic rd_alt;
    logic rd_dh;
    logic wr_ctrl;
    logic wr_dh;
    logic card_no;

    // Reset sequencing keeps busy set through and shortly after reset.
    assign busy = CORE_BUSY_I | (st.mode != atsc_pkg::ATSC_RUN);

    assign rd_status = hit(REG_RD_I, REG_ADDR_I, atsc_pkg::OFS_STATUS);
    assign rd_alt    = hit(REG_RD_I, REG_ADDR_I, atsc_pkg::OFS_ALT_STATUS);
    assign rd_dh     = hit(REG_RD_I, REG_ADDR_I, atsc_pkg::OFS_DRIVE_HEAD);
    assign wr_ctrl   = hit(REG_WR_I, REG_ADDR_I, atsc_pkg::OFS_DEV_CTRL);
    assign wr_dh     = hit(REG_WR_I, REG_ADDR_I, atsc_pkg::OFS_DRIVE_HEAD);

    // In PC Card modes the configured copy decides our card number.
    assign card_no = PCCARD_MODE_I ? COPY_FIELD_I[0] : OWN_CARD;

    // Flags feeding the status builder.
    assign lnk.busy   = busy;
    assign lnk.ready  = CORE_READY_I & (st.mode == atsc_pkg::ATSC_RUN);
    assign lnk.wfault = WRITE_FAULT_I;
    assign lnk.seek   = SEEK_DONE_I;
    assign lnk.data_request_flag    = DATA_REQ_I;
    assign lnk.corrected_error_flag   = st.corrected_error_flag;
    assign lnk.err    = CMD_ERROR_I;

    // Bytes feeding the address decoder.
    assign lnk.dh     = st.drive_head;
    assign lnk.sec    = SECTOR_NUM_I;
    assign lnk.cyl_lo = CYL_LOW_I;
    assign lnk.cyl_hi = CYL_HIGH_I;

    atsc_status u_status (
        .lnk (lnk.stat_mp)
    );

    atsc_addr u_addr (
        .lnk (lnk.addr_mp)
    );

    // Next state: host accesses, reset sequencing and flag upkeep.
    always_comb begin
        next_st = st;

        // Only bits 2 and 1 of a control write have any effect.
        if (wr_ctrl) begin
            next_st.soft_reset   = REG_WDATA_I[atsc_pkg::DC_SOFT_RESET];
            next_st.irq_enable_n = REG_WDATA_I[atsc_pkg::DC_IRQ_EN_N];
        end

        // Drive/head writes are dropped while the device owns the
        // registers, so a stray write cannot move a transfer in flight.
        if (wr_dh && !busy) begin
            next_st.drive_head = REG_WDATA_I | atsc_pkg::DH_FIXED;
        end

        // A corrected error stays visible until the next primary read;
        // a new event in the clearing cycle wins over the clear.
        if (rd_status) begin
            next_st.corrected_error_flag = 1'b0;
        end
        if (CORRECTED_ERROR_FLAG_EVENT_I) begin
            next_st.corrected_error_flag = 1'b1;
        end

        // Primary read clears the request, the copy leaves it alone.
        if (rd_status) begin
            next_st.irq_pending = 1'b0;
        end
        if (IRQ_EVENT_I) begin
            next_st.irq_pending = 1'b1;
        end

        // Soft reset sequencing. Configuration inputs are never
        // touched here; only task-file state returns to defaults.
        next_st.rec_cnt = st.rec_cnt;
        case (st.mode)
            atsc_pkg::ATSC_RUN: begin
                if (next_st.soft_reset) begin
                    next_st.mode = atsc_pkg::ATSC_SRST;
                end
            end
            atsc_pkg::ATSC_SRST: begin
                if (!next_st.soft_reset) begin
                    next_st.mode    = atsc_pkg::ATSC_RECOVER;
                    next_st.rec_cnt = REC_LOAD;
                end
            end
            atsc_pkg::ATSC_RECOVER: begin
                if (next_st.soft_reset) begin
                    next_st.mode = atsc_pkg::ATSC_SRST;
                end else if (st.rec_cnt <= 4'h1) begin
                    next_st.mode    = atsc_pkg::ATSC_RUN;
                    next_st.rec_cnt = 4'h0;
                end else begin
                    next_st.rec_cnt = st.rec_cnt - 4'h1;
                end
            end
            default: begin
                next_st.mode = atsc_pkg::ATSC_RUN;
            end
        endcase

        // Held in soft reset: task-file state cleared, events dropped.
        if (st.mode == atsc_pkg::ATSC_SRST) begin
            next_st.drive_head  = atsc_pkg::DH_RESET;
            next_st.corrected_error_flag        = 1'b0;
            next_st.irq_pending = 1'b0;
        end

        // Status snapshot; bits 5 and 4 pass write fault and seek complete.
        next_st.status = lnk.status;

        // Read data; the copy at Eh returns the same byte as offset 7.
        if (rd_status || rd_alt) begin
            next_st.rdata = st.status;
        end else if (rd_dh) begin
            next_st.rdata = st.drive_head;
        end else if (REG_RD_I) begin
            next_st.rdata = atsc_pkg::RD_UNUSED;
        end

        // Interrupt leaves only while enabled and out of soft reset.
        next_st.irq_out = next_st.irq_pending & ~next_st.irq_enable_n
                          & ~next_st.soft_reset;
        next_st.cfg_int = next_st.irq_pending
                          & ~next_st.irq_enable_n;

        // Drive bit matched against our card number.
        next_st.card_sel = next_st.drive_head[atsc_pkg::DH_DRIVE]
                           == card_no;

        // Head or top address nibble from the decoder.
        next_st.logical_block_mode      = lnk.logical_block_mode;
        next_st.head     = lnk.head;
        next_st.lba_mode = lnk.lba_mode;
    end

    // State register; hardware reset clears everything except drive/head, which loads DH_RESET.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st              <= '0;
            st.mode         <= atsc_pkg::ATSC_RUN;
            st.drive_head   <= atsc_pkg::DH_RESET;
            st.irq_enable_n <= 1'b0;
            st.card_sel     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register.
    assign REG_RDATA_O  = st.rdata;
    assign IRQ_O        = st.irq_out;
    assign CFG_INT_O    = st.cfg_int;
    assign SOFT_RESET_O = st.soft_reset;
    assign CARD_SEL_O   = st.card_sel;
    assign LBA_O        = st.logical_block_mode;
    assign HEAD_O       = st.head;
    assign LBA_MODE_O   = st.lba_mode;

    // Checks on the behaviour above.
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    a_alt_keeps_irq: assert property (
        rd_alt && !IRQ_EVENT_I && st.mode == atsc_pkg::ATSC_RUN
        |=> st.irq_pending == $past(st.irq_pending))
        else $error("alternate status read changed interrupt");

    a_prim_clears_irq: assert property (
        rd_status && !IRQ_EVENT_I |=> !st.irq_pending && !IRQ_O)
        else $error("primary status read left interrupt set");

    a_srst_busy: assert property (
        st.soft_reset |=> st.status[atsc_pkg::ST_BUSY])
        else $error("busy clear during soft reset");

    a_srst_holds: assert property (
        st.soft_reset && !wr_ctrl |=> st.soft_reset)
        else $error("soft reset ended without a write");

    a_index_zero: assert property (
        REG_RD_I && REG_ADDR_I == atsc_pkg::OFS_STATUS
        |=> !REG_RDATA_O[atsc_pkg::ST_INDEX])
        else $error("index bit read as one");

    a_ien_blocks: assert property (
        st.irq_enable_n && $past(st.irq_enable_n) |-> !IRQ_O)
        else $error("interrupt raised while disabled");

    a_ien_reset: assert property (
        $past(RST_I) |-> !st.irq_enable_n && !IRQ_O)
        else $error("interrupt enable not zero after reset");

    // The reset edge itself is left out: the register clears there, so the
    // joined address only follows the inputs from the next edge on.
    a_lba_join: assert property (
        !RST_I |=> LBA_O == {$past(st.drive_head[3:0]), $past(CYL_HIGH_I),
                      $past(CYL_LOW_I), $past(SECTOR_NUM_I)})
        else $error("block address assembled wrongly");

    a_dh_busy_hold: assert property (
        wr_dh && busy && st.mode == atsc_pkg::ATSC_RUN
        |=> st.drive_head == $past(st.drive_head))
        else $error("drive/head written while busy");

    a_status_copy: assert property (
        rd_alt |=> REG_RDATA_O == $past(st.status))
        else $error("alternate status differs from status");

    a_ready_low: assert property (
        !CORE_READY_I |=> !st.status[atsc_pkg::ST_READY])
        else $error("ready shown before core ready");

    a_card_pick: assert property (
        PCCARD_MODE_I && !RST_I |=> CARD_SEL_O == (st.drive_head[4]
                          == $past(COPY_FIELD_I[0])))
        else $error("card selection ignores copy field");

endmodule
`default_nettype wire

/* File: atsc_pkg.sv */
// Shared constants and state type of the task-file status/control block.
// Assumes an 8-bit task-file port with a 4-bit register offset.
package atsc_pkg;

    // Register offsets on the task-file port.
    localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
    localparam logic [3:0] OFS_STATUS     = 4'h7;
    localparam logic [3:0] OFS_ALT_STATUS = 4'he;
    localparam logic [3:0] OFS_DEV_CTRL   = 4'he;

    // Drive/head field positions.
    localparam int DH_LBA_MODE = 6;
    localparam int DH_DRIVE    = 4;
    localparam int DH_HEAD_MSB = 3;

    // Status field positions.
    localparam int ST_BUSY   = 7;
    localparam int ST_READY  = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_SEEK   = 4;
    localparam int ST_DRQ    = 3;
    localparam int ST_CORRECTED_ERROR_FLAG   = 2;
    localparam int ST_INDEX  = 1;
    localparam int ST_ERROR  = 0;

    // Device control field positions.
    localparam int DC_SOFT_RESET = 2;
    localparam int DC_IRQ_EN_N   = 1;

    // Reset values; bits 7 and 5 of drive/head always read as one.
    localparam logic [7:0] DH_RESET  = 8'ha0;
    localparam logic [7:0] DH_FIXED  = 8'ha0;
    localparam logic [7:0] RD_UNUSED = 8'h00;

    // Busy cycles held after a soft reset is released.
    localparam int RECOVER_CYCLES = 4;

    typedef enum logic [1:0] {
        ATSC_RUN     = 2'b00,
        ATSC_SRST    = 2'b01,
        ATSC_RECOVER = 2'b10
    } atsc_mode_t;

    typedef struct packed {
        atsc_mode_t  mode;
        logic [3:0]  rec_cnt;
        logic [7:0]  drive_head;
        logic        soft_reset;
        logic        irq_enable_n;
        logic        irq_pending;
        logic        corrected_error_flag;
        logic [7:0]  status;
        logic [7:0]  rdata;
        logic        irq_out;
        logic        cfg_int;
        logic        card_sel;
        logic [27:0] logical_block_mode;
        logic [3:0]  head;
        logic        lba_mode;
    } atsc_state_t;

endpackage

/* File: atsc_link_if.sv */
// Interface joining the top module to its status and address helpers.
// Assumes all three run on the one block clock.
`timescale 1ns/1ps
`default_nettype none
interface atsc_link_if;
    logic        busy;
    logic        ready;
    logic        wfault;
    logic        seek;
    logic        data_request_flag;
    logic        corrected_error_flag;
    logic        err;
    logic [7:0]  status;
    logic [7:0]  dh;
    logic [7:0]  sec;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [27:0] logical_block_mode;
    logic [3:0]  head;
    logic        lba_mode;

    modport stat_mp (input busy, ready, wfault, seek, data_request_flag, corrected_error_flag, err,
                     output status);
    modport addr_mp (input dh, sec, cyl_lo, cyl_hi,
                     output logical_block_mode, head, lba_mode);
endinterface
`default_nettype wire

/* File: atsc_status.sv */
// Combinational status byte builder.
// Assumes the caller registers the result before showing it to the host.
`timescale 1ns/1ps
`default_nettype none
module atsc_status (
    atsc_link_if.stat_mp lnk    // Status flags in, status byte out.
);
    // While busy the other bits are not trusted by the host, so all but ready are
    // still passed through rather than forced, which keeps the logic flat.
    always_comb begin
        lnk.status                     = 8'h00;
        lnk.status[atsc_pkg::ST_BUSY]   = lnk.busy;
        lnk.status[atsc_pkg::ST_READY]  = lnk.ready & ~lnk.busy;
        lnk.status[atsc_pkg::ST_WFAULT] = lnk.wfault;
        lnk.status[atsc_pkg::ST_SEEK]   = lnk.seek;
        lnk.status[atsc_pkg::ST_DRQ]    = lnk.data_request_flag;
        lnk.status[atsc_pkg::ST_CORRECTED_ERROR_FLAG]   = lnk.corrected_error_flag;
        lnk.status[atsc_pkg::ST_INDEX]  = 1'b0;
        lnk.status[atsc_pkg::ST_ERROR]  = lnk.err;
    end
endmodule
`default_nettype wire

/* File: atsc_addr.sv */
// Combinational block-address and head decoder.
// Assumes sector and cylinder bytes come from the task-file neighbours.
`timescale 1ns/1ps
`default_nettype none
module atsc_addr (
    atsc_link_if.addr_mp lnk    // Task-file bytes in, address out.
);
    // Low drive/head nibble is the head number or the top address nibble.
    always_comb begin
        lnk.lba_mode = lnk.dh[atsc_pkg::DH_LBA_MODE];
        lnk.head     = lnk.dh[atsc_pkg::DH_HEAD_MSB:0];
        lnk.logical_block_mode      = {lnk.dh[atsc_pkg::DH_HEAD_MSB:0], lnk.cyl_hi,
                        lnk.cyl_lo, lnk.sec};
    end
endmodule
`default_nettype wire

/* File: atsc_host_model.sv */
// Host controller model driving the task-file register port.
// Assumes the block takes a strobe at the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module atsc_host_model (
    input  wire logic       clk_i,    // Block clock.
    input  wire logic [7:0] rdata_i,  // Read data from the block.
    output logic      [3:0] addr_o,   // Task-file offset.
    output logic      [7:0] wdata_o,  // Write data.
    output logic            wr_o,     // Write strobe pulse.
    output logic            rd_o      // Read strobe pulse.
);
    // The port is idle from time zero.
    initial begin
        addr_o  = 4'h0;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // One-cycle write; released data is inverted so it never looks held.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask

    // One-cycle read; data holds after the answer, so it is taken late.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask

    // Drive/head write once status shows the device idle, or after 50 busy status reads.
    task automatic wr_dh(input logic [7:0] d);
        logic [7:0] s;
        s = 8'hff;
        for (int i = 0; i < 50 && s[7] !== 1'b0; i++) begin
            rd(4'h7, s);
        end
        wr(4'h6, d);
    endtask

    // Soft reset is held, then written back to zero to release it.
    task automatic soft_reset(input logic [7:0] keep);
        wr(4'he, keep | 8'h04);
        wr(4'he, keep & 8'hfb);
    endtask
endmodule
`default_nettype wire

/* File: ata_taskfile_status_control_test.sv */
// Self-checking bench for the task-file status and control block.
// Assumes atsc_pkg, the link interface and the design files are compiled.
`timescale 1ns/1ps
`default_nettype none
module ata_taskfile_status_control_test;
    localparam int REC = atsc_pkg::RECOVER_CYCLES;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pcm = 1'b0;
    logic [2:0]  copy = 3'h0;
    logic [5:0]  flg = 6'h00;
    logic [1:0]  ev = 2'h0;
    logic [7:0]  sec = 8'h12;
    logic [7:0]  cyl_lo = 8'h34;
    logic [7:0]  cyl_hi = 8'h56;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        irq;
    logic        cfg_int;
    logic        srst;
    logic        csel;
    logic [27:0] logical_block_mode;
    logic [3:0]  head;
    logic        lba_mode;
    logic [7:0]  d;
    int          n_fail = 0;
    int          n_checks = 0;

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    atsc_top #(.DRIVE_ID(0), .RECOVER_CYCLES(REC)) i_dut (
        .CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .PCCARD_MODE_I(pcm),
        .COPY_FIELD_I(copy), .CORE_BUSY_I(flg[5]), .CORE_READY_I(flg[4]),
        .WRITE_FAULT_I(flg[3]), .SEEK_DONE_I(flg[2]), .DATA_REQ_I(flg[1]),
        .CORRECTED_ERROR_FLAG_EVENT_I(ev[0]), .CMD_ERROR_I(flg[0]), .IRQ_EVENT_I(ev[1]),
        .SECTOR_NUM_I(sec), .CYL_LOW_I(cyl_lo), .CYL_HIGH_I(cyl_hi),
        .REG_RDATA_O(rdata), .IRQ_O(irq), .CFG_INT_O(cfg_int),
        .SOFT_RESET_O(srst), .CARD_SEL_O(csel), .LBA_O(logical_block_mode),
        .HEAD_O(head), .LBA_MODE_O(lba_mode));

    atsc_host_model i_host (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    // Compare one value and count the outcome.
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Let n edges pass, then look once their updates have landed.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle event pulse: bit 1 interrupt cause, bit 0 corrected error.
    task automatic pulse(input logic [1:0] s);
        @(posedge clk);
        ev <= s;
        @(posedge clk);
        ev <= 2'h0;
        settle(3);
    endtask

    // Synchronous reset held for 20 cycles.
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The tests take a few hundred cycles at most; this 4000-cycle limit cuts a hang.
    initial begin
        #20000;
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Each core flag alone, seen identically at both status offsets.
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            flg <= 6'h01 << i;
            settle(3);
            i_host.rd(4'h7, d);
            chk("status", d, {flg[5:1], 2'b00, flg[0]});
            i_host.rd(4'he, d);
            chk("alt status", d, {flg[5:1], 2'b00, flg[0]});
        end
        @(posedge clk);
        flg <= 6'h00;
        settle(3);
        i_host.rd(4'h7, d);
        chk("idle status", d, 8'h00);
        $display("status flag test done");

        // Corrected error sticks past a copy read, clears on primary read.
        pulse(2'b01);
        i_host.rd(4'he, d);
        chk("corrected_error_flag alt", d, 8'h04);
        i_host.rd(4'h7, d);
        chk("corrected_error_flag primary", d, 8'h04);
        i_host.rd(4'h7, d);
        chk("corrected_error_flag cleared", d, 8'h00);
        $display("corrected error test done");

        // Interrupt enabled after reset; copy read keeps it, primary clears.
        pulse(2'b10);
        chk("irq after reset", irq, 1'b1);
        chk("cfg int", cfg_int, 1'b1);
        i_host.rd(4'he, d);
        settle(2);
        chk("irq after alt read", irq, 1'b1);
        i_host.rd(4'h7, d);
        settle(2);
        chk("irq after read", irq, 1'b0);
        // Disable with every ignored bit set, then enable again.
        i_host.wr(4'he, 8'hfb);
        pulse(2'b10);
        chk("irq masked", irq, 1'b0);
        chk("cfg int masked", cfg_int, 1'b0);
        chk("no soft reset", srst, 1'b0);
        i_host.wr(4'he, 8'hf9);
        settle(2);
        chk("irq unmasked", irq, 1'b1);
        chk("cfg int unmasked", cfg_int, 1'b1);
        chk("no soft reset 2", srst, 1'b0);
        i_host.rd(4'he, d);
        chk("control write only", d, 8'h00);
        i_host.rd(4'h7, d);
        $display("interrupt test done");

        // Drive/head fields, block address and card selection.
        i_host.wr_dh(8'h5b);
        i_host.rd(4'h6, d);
        chk("drive head", d, 8'hfb);
        settle(2);
        chk("lba", logical_block_mode, 28'hb563412);
        chk("head", head, 4'hb);
        chk("lba mode", lba_mode, 1'b1);
        chk("card sel drive 1", csel, 1'b0);
        i_host.wr_dh(8'h04);
        settle(2);
        chk("head chs", head, 4'h4);
        chk("chs mode", lba_mode, 1'b0);
        chk("card sel drive 0", csel, 1'b1);
        @(posedge clk);
        pcm  <= 1'b1;
        copy <= 3'h1;
        settle(3);
        chk("pc card copy 1", csel, 1'b0);
        i_host.wr_dh(8'h10);
        settle(2);
        chk("pc card drive 1", csel, 1'b1);
        i_host.rd(4'h3, d);
        chk("unmapped read", d, 8'h00);
        $display("drive head test done");

        // Soft reset: busy, refused write, recovery, pending irq dropped.
        @(posedge clk);
        flg <= 6'h14;
        pulse(2'b10);
        i_host.wr(4'he, 8'h04);
        settle(2);
        chk("soft reset out", srst, 1'b1);
        chk("irq in soft reset", irq, 1'b0);
        i_host.rd(4'h7, d);
        chk("busy in reset", d[7], 1'b1);
        i_host.wr(4'h6, 8'h0f);
        i_host.wr(4'he, 8'h00);
        i_host.rd(4'h7, d);
        chk("busy in recovery", d[7], 1'b1);
        settle(REC + 6);
        i_host.rd(4'h7, d);
        chk("ready after reset", d, 8'h50);
        chk("irq dropped by soft reset", irq, 1'b0);
        i_host.rd(4'h6, d);
        chk("drive head cleared", d, 8'ha0);
        chk("config copy kept", csel, 1'b0);
        $display("soft reset test done");

        // Hardware reset in mid-run re-enables interrupts.
        i_host.wr(4'he, 8'h02);
        do_reset();
        pulse(2'b10);
        chk("irq after hw reset", irq, 1'b1);
        i_host.rd(4'h6, d);
        chk("drive head hw reset", d, 8'ha0);
        $display("hardware reset test done");
        complete_run();
    end
endmodule
`default_nettype wire
